// ===== logic/acfg_config.sv
// Serial configuration decoder of a multichannel 12-bit converter: setup,
// pair-mode and averaging registers, start control and result formatting.
// Assumes serial pins and the start pin are asynchronous to clk; converter,
// conversion register and result storage are neighbouring logic on clk.
`timescale 1ns/100ps
`default_nettype none

module acfg_config
	import acfg_pkg::*;
#(
	parameter int NUM_CHANNELS = 16,
	parameter logic [RESULT_BITS-1:0] TEMP_KELVIN_OFFSET = 12'h889
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	input wire logic conversion_start_pin,
	input wire logic scan_active,
	input wire logic [1:0] conv_scan_mode,
	input wire logic conv_result_valid,
	input wire logic [RESULT_BITS-1:0] conv_result_code,
	input wire logic conv_result_bipolar,
	input wire logic temp_codes_valid,
	input wire logic [RESULT_BITS-1:0] temp_hot_code,
	input wire logic [RESULT_BITS-1:0] temp_cold_code,
	output logic [7:0] setup_config,
	output logic [7:0] unipolar_pair_enable,
	output logic [7:0] bipolar_pair_enable,
	output logic [7:0] averaging_config,
	output logic [7:0] conv_byte,
	output logic conv_byte_stb,
	output logic start_conversion,
	output logic acquire_hold,
	output logic conv_clk_en,
	output logic use_internal_clock,
	output logic start_pin_used,
	output logic ref_use_internal,
	output logic ref_power_en,
	output logic ref_wake_required,
	output logic ref_ext_diff,
	output logic [7:0] pair_unipolar,
	output logic [7:0] pair_bipolar,
	output logic [5:0] conversions_per_result,
	output logic [4:0] results_per_request,
	output logic [RESULT_BITS-1:0] temp_celsius_code
);

	typedef struct packed {
		logic [1:0] cs_sync;
		logic [1:0] sclk_sync;
		logic [1:0] din_sync;
		logic [1:0] start_sync;
		logic cs_prev;
		logic sclk_prev;
		logic start_prev;
		acfg_rx_e rx_state;
		logic pair_to_bipolar;
		logic [2:0] bit_cnt;
		logic [6:0] rx_bits;
		logic [7:0] setup;
		logic [7:0] uni;
		logic [7:0] bip;
		logic [7:0] avg;
		logic [7:0] conv;
		logic conv_stb;
		logic start;
		logic acquire;
		logic conv_clk;
		logic ref_on;
		logic ref_wake;
		logic out_en;
		logic [WORD_BITS-1:0] result_word;
		logic [RESULT_BITS-1:0] temp_code;
		logic [5:0] avg_n;
		logic [4:0] rep_n;
	} acfg_state_s;

	acfg_state_s s_ff;
	acfg_state_s nxt_s;

	logic shift_load;
	logic shift_step;

	// Only the second stage of each synchroniser is read
	logic cs_low;
	logic sclk_lvl;
	logic din_lvl;
	logic start_lvl;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic start_rise;
	logic [1:0] clk_mode;
	logic [1:0] ref_mode;

	assign cs_low = ~s_ff.cs_sync[1];
	assign sclk_lvl = s_ff.sclk_sync[1];
	assign din_lvl = s_ff.din_sync[1];
	assign start_lvl = s_ff.start_sync[1];
	assign sclk_rise = cs_low & sclk_lvl & ~s_ff.sclk_prev;
	assign sclk_fall = cs_low & ~sclk_lvl & s_ff.sclk_prev;
	assign cs_fall = cs_low & s_ff.cs_prev;
	// One sampled low cycle already meets the least low time of the pin
	assign start_rise = start_lvl & ~s_ff.start_prev;
	assign clk_mode = s_ff.setup[SETUP_CLK_HI:SETUP_CLK_LO];
	assign ref_mode = s_ff.setup[SETUP_REF_HI:SETUP_REF_LO];

	always_comb begin
		logic [7:0] rx_byte;
		logic [RESULT_BITS-1:0] fmt;
		rx_byte = {s_ff.rx_bits, din_lvl};
		fmt = '0;
		nxt_s = s_ff;

		nxt_s.cs_sync = {s_ff.cs_sync[0], cs_n};
		nxt_s.sclk_sync = {s_ff.sclk_sync[0], sclk};
		nxt_s.din_sync = {s_ff.din_sync[0], din};
		nxt_s.start_sync = {s_ff.start_sync[0], conversion_start_pin};
		nxt_s.cs_prev = s_ff.cs_sync[1];
		nxt_s.sclk_prev = sclk_lvl;
		nxt_s.start_prev = start_lvl;
		nxt_s.conv_stb = 1'b0;
		nxt_s.start = 1'b0;
		nxt_s.conv_clk = 1'b0;
		nxt_s.out_en = cs_low;

		// Frame end drops any half byte and any pending pair data
		if (!cs_low) begin
			nxt_s.bit_cnt = '0;
			nxt_s.rx_state = RX_CMD;
		end else if (sclk_rise) begin
			nxt_s.rx_bits = rx_byte[6:0];
			nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
			if (s_ff.bit_cnt == 3'h7) begin
				case (s_ff.rx_state)
					RX_PAIR: begin
						// Pair data byte is never decoded as a command
						if (s_ff.pair_to_bipolar) begin
							nxt_s.bip = rx_byte;
						end else begin
							nxt_s.uni = rx_byte;
						end
						nxt_s.rx_state = RX_CMD;
					end
					RX_CMD: begin
						if (rx_byte[CMD_CONV_BIT]) begin
							nxt_s.conv = rx_byte;
							nxt_s.conv_stb = 1'b1;
							if (clk_mode[1]) begin
								nxt_s.start = 1'b1;
							end
						end else if (rx_byte[7:6] == CMD_SETUP_TAG) begin
							nxt_s.setup = rx_byte;
							// Select 0x expects no data byte
							if (rx_byte[SETUP_DIFF_HI]) begin
								nxt_s.rx_state = RX_PAIR;
								nxt_s.pair_to_bipolar = rx_byte[SETUP_DIFF_LO];
							end
						end else if (rx_byte[7:5] == CMD_AVG_TAG) begin
							nxt_s.avg = rx_byte;
						end
					end
					default: begin
						nxt_s.rx_state = RX_CMD;
					end
				endcase
			end
		end

		// Conversion start and acquisition timing per clock mode
		case (clk_mode)
			CLK_MODE_PIN_INT: begin
				nxt_s.acquire = 1'b0;
				if (start_rise) begin
					nxt_s.start = 1'b1;
				end
			end
			CLK_MODE_PIN_ACQ: begin
				// Pin low tracks, rising edge converts on the internal clock
				nxt_s.acquire = ~start_lvl;
				if (start_rise) begin
					nxt_s.start = 1'b1;
				end
			end
			CLK_MODE_SER_EXT: begin
				nxt_s.acquire = 1'b0;
				// Host keeps the serial clock slow enough to sample here
				nxt_s.conv_clk = sclk_rise;
			end
			default: begin
				nxt_s.acquire = 1'b0;
			end
		endcase

		// Reference power and wake-up
		case (ref_mode)
			REF_MODE_INT_AUTO: begin
				// Powered only while a scan runs, so each new scan waits
				nxt_s.ref_on = scan_active;
				nxt_s.ref_wake = ~s_ff.ref_on;
			end
			REF_MODE_INT_ON: begin
				nxt_s.ref_on = 1'b1;
				nxt_s.ref_wake = 1'b0;
			end
			default: begin
				nxt_s.ref_on = 1'b0;
				nxt_s.ref_wake = 1'b0;
			end
		endcase

		// Conversions per result; the serial-clocked mode never averages
		if (!s_ff.avg[AVG_EN_BIT] || clk_mode == CLK_MODE_SER_EXT) begin
			nxt_s.avg_n = AVG_N1;
		end else begin
			case (s_ff.avg[AVG_CNT_HI:AVG_CNT_LO])
				2'h0: nxt_s.avg_n = AVG_N4;
				2'h1: nxt_s.avg_n = AVG_N8;
				2'h2: nxt_s.avg_n = AVG_N16;
				default: nxt_s.avg_n = AVG_N32;
			endcase
		end

		if (conv_scan_mode == SCAN_MODE_REPEAT) begin
			nxt_s.rep_n = 5'(({3'h0, s_ff.avg[AVG_REP_HI:AVG_REP_LO]} + 5'h01) * REPEAT_STEP);
		end else begin
			nxt_s.rep_n = REPEAT_ONE;
		end

		// Temperature code: hot-bias minus cold-bias, Kelvin to Celsius
		if (temp_codes_valid) begin
			nxt_s.temp_code = temp_hot_code - temp_cold_code - TEMP_KELVIN_OFFSET;
		end

		// Output word; temperature has priority over an ordinary result
		if (temp_codes_valid) begin
			fmt = temp_hot_code - temp_cold_code - TEMP_KELVIN_OFFSET;
			nxt_s.result_word = {{LEAD_ZERO_BITS{1'b0}}, fmt};
		end else if (conv_result_valid) begin
			// Converter delivers offset binary; flipping the MSB gives two's complement
			fmt = conv_result_bipolar ? (conv_result_code ^ BIPOLAR_FLIP) : conv_result_code;
			nxt_s.result_word = {{LEAD_ZERO_BITS{1'b0}}, fmt};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff.cs_sync <= 2'h3;
			s_ff.sclk_sync <= 2'h0;
			s_ff.din_sync <= 2'h0;
			s_ff.start_sync <= 2'h3;
			s_ff.cs_prev <= 1'b1;
			s_ff.sclk_prev <= 1'b0;
			s_ff.start_prev <= 1'b1;
			s_ff.rx_state <= RX_CMD;
			s_ff.pair_to_bipolar <= 1'b0;
			s_ff.bit_cnt <= 3'h0;
			s_ff.rx_bits <= 7'h00;
			s_ff.setup <= SETUP_RESET;
			s_ff.uni <= PAIR_RESET;
			s_ff.bip <= PAIR_RESET;
			s_ff.avg <= AVG_RESET;
			s_ff.conv <= 8'h00;
			s_ff.conv_stb <= 1'b0;
			s_ff.start <= 1'b0;
			s_ff.acquire <= 1'b0;
			s_ff.conv_clk <= 1'b0;
			s_ff.ref_on <= 1'b0;
			s_ff.ref_wake <= 1'b1;
			s_ff.out_en <= 1'b0;
			s_ff.result_word <= '0;
			s_ff.temp_code <= '0;
			s_ff.avg_n <= AVG_N1;
			s_ff.rep_n <= REPEAT_ONE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Word is reloaded at frame start and advances on falling serial edges
	assign shift_load = cs_fall;
	assign shift_step = sclk_fall;

	acfg_result_shifter u_shifter (
		.clk(clk),
		.rst(rst),
		.load(shift_load),
		.load_word(s_ff.result_word),
		.shift(shift_step),
		.dout(dout)
	);

	// Pair decode; index is the pair number, register bit 7 is pair 0/1
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pair
			localparam bit PAIR_PRESENT = (2 * gi + 1) < NUM_CHANNELS;
			assign pair_unipolar[gi] = PAIR_PRESENT & s_ff.uni[7 - gi];
			// Unipolar setting overrides a bipolar one for the same pair
			assign pair_bipolar[gi] = PAIR_PRESENT & s_ff.bip[7 - gi] & ~s_ff.uni[7 - gi];
		end
	endgenerate

	assign dout_oe = s_ff.out_en;
	assign setup_config = s_ff.setup;
	assign unipolar_pair_enable = s_ff.uni;
	assign bipolar_pair_enable = s_ff.bip;
	assign averaging_config = s_ff.avg;
	assign conv_byte = s_ff.conv;
	assign conv_byte_stb = s_ff.conv_stb;
	assign start_conversion = s_ff.start;
	assign acquire_hold = s_ff.acquire;
	assign conv_clk_en = s_ff.conv_clk;
	assign use_internal_clock = (clk_mode != CLK_MODE_SER_EXT);
	assign start_pin_used = ~clk_mode[1];
	assign ref_use_internal = ~ref_mode[0];
	assign ref_power_en = s_ff.ref_on;
	assign ref_wake_required = s_ff.ref_wake & (ref_mode == REF_MODE_INT_AUTO);
	assign ref_ext_diff = (ref_mode == REF_MODE_EXT_DIFF);
	assign conversions_per_result = s_ff.avg_n;
	assign results_per_request = s_ff.rep_n;
	assign temp_celsius_code = s_ff.temp_code;

endmodule
`default_nettype wire

// ===== logic/acfg_pkg.sv
// Constants shared by the converter configuration decoder and its result shifter.
// Assumes a single 25 MHz system clock; serial pins arrive asynchronously.
package acfg_pkg;

	// System clock
	localparam int CLK_PERIOD_NS = 40;

	// Conversion-start pin least low time, rounded up to whole cycles
	localparam int START_PIN_LOW_NS = 40;
	localparam int START_PIN_LOW_CYC_RAW = (START_PIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_PIN_LOW_CYC = (START_PIN_LOW_CYC_RAW < 1) ? 1 : START_PIN_LOW_CYC_RAW;

	// Highest serial clock the host may use while it clocks conversions
	localparam int SCLK_CONV_MAX_KHZ = 4800;

	// Command byte selection
	localparam int CMD_CONV_BIT = 7;
	localparam logic [1:0] CMD_SETUP_TAG = 2'h1;
	localparam logic [2:0] CMD_AVG_TAG = 3'h1;

	// Setup register fields
	localparam int SETUP_CLK_HI = 5;
	localparam int SETUP_CLK_LO = 4;
	localparam int SETUP_REF_HI = 3;
	localparam int SETUP_REF_LO = 2;
	localparam int SETUP_DIFF_HI = 1;
	localparam int SETUP_DIFF_LO = 0;

	// Averaging register fields
	localparam int AVG_EN_BIT = 4;
	localparam int AVG_CNT_HI = 3;
	localparam int AVG_CNT_LO = 2;
	localparam int AVG_REP_HI = 1;
	localparam int AVG_REP_LO = 0;

	// Reset values
	localparam logic [7:0] SETUP_RESET = 8'h20;
	localparam logic [7:0] PAIR_RESET = 8'h00;
	localparam logic [7:0] AVG_RESET = 8'h00;

	// Clock modes
	localparam logic [1:0] CLK_MODE_PIN_INT = 2'h0;
	localparam logic [1:0] CLK_MODE_PIN_ACQ = 2'h1;
	localparam logic [1:0] CLK_MODE_SER_INT = 2'h2;
	localparam logic [1:0] CLK_MODE_SER_EXT = 2'h3;

	// Reference modes
	localparam logic [1:0] REF_MODE_INT_AUTO = 2'h0;
	localparam logic [1:0] REF_MODE_EXT_SE = 2'h1;
	localparam logic [1:0] REF_MODE_INT_ON = 2'h2;
	localparam logic [1:0] REF_MODE_EXT_DIFF = 2'h3;

	// Scan mode that repeats one channel
	localparam logic [1:0] SCAN_MODE_REPEAT = 2'h2;

	// Conversions per result
	localparam logic [5:0] AVG_N1 = 6'h01;
	localparam logic [5:0] AVG_N4 = 6'h04;
	localparam logic [5:0] AVG_N8 = 6'h08;
	localparam logic [5:0] AVG_N16 = 6'h10;
	localparam logic [5:0] AVG_N32 = 6'h20;

	// Results per single-channel scan: (code + 1) * 4
	localparam logic [4:0] REPEAT_STEP = 5'h04;
	localparam logic [4:0] REPEAT_ONE = 5'h01;

	// Output word
	localparam int RESULT_BITS = 12;
	localparam int LEAD_ZERO_BITS = 4;
	localparam int WORD_BITS = RESULT_BITS + LEAD_ZERO_BITS;
	localparam logic [RESULT_BITS-1:0] BIPOLAR_FLIP = 12'h800;

	// Temperature diode bias currents, microamps
	localparam int TEMP_HOT_UA = 68;
	localparam int TEMP_COLD_UA = 4;

	// Receiver states
	typedef enum logic [1:0] {
		RX_CMD = 2'b01,
		RX_PAIR = 2'b10
	} acfg_rx_e;

endpackage

// ===== logic/acfg_result_shifter.sv
// Output shifter for the 16-bit serial result word.
// Assumes load and shift are one-cycle pulses of the 25 MHz clock domain.
`timescale 1ns/100ps
`default_nettype none

module acfg_result_shifter
	import acfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [WORD_BITS-1:0] load_word,
	input wire logic shift,
	output logic dout
);

	typedef struct packed {
		logic [WORD_BITS-1:0] word;
	} acfg_shift_s;

	acfg_shift_s s_ff;
	acfg_shift_s nxt_s;

	always_comb begin
		nxt_s = s_ff;
		// Load wins so a fresh frame never starts mid-word
		if (load) begin
			nxt_s.word = load_word;
		end else if (shift) begin
			nxt_s.word = {s_ff.word[WORD_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign dout = s_ff.word[WORD_BITS-1];

endmodule
`default_nettype wire

// ===== verif/acfg_config_asserts.sv
// Checker for the converter configuration decoder.
// Sees only the decoder's ports; attached by bind from the bench top.
`timescale 1ns/100ps
`default_nettype none

module acfg_config_asserts
	import acfg_pkg::*;
#(
	parameter int NUM_CHANNELS = 16,
	parameter logic [RESULT_BITS-1:0] TEMP_KELVIN_OFFSET = 12'h889
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic conversion_start_pin,
	input wire logic scan_active,
	input wire logic [1:0] conv_scan_mode,
	input wire logic temp_codes_valid,
	input wire logic [RESULT_BITS-1:0] temp_hot_code,
	input wire logic [RESULT_BITS-1:0] temp_cold_code,
	input wire logic [7:0] setup_config,
	input wire logic [7:0] unipolar_pair_enable,
	input wire logic [7:0] bipolar_pair_enable,
	input wire logic [7:0] averaging_config,
	input wire logic conv_byte_stb,
	input wire logic start_conversion,
	input wire logic dout_oe,
	input wire logic conv_clk_en,
	input wire logic ref_power_en,
	input wire logic ref_wake_required,
	input wire logic [7:0] pair_unipolar,
	input wire logic [7:0] pair_bipolar,
	input wire logic [5:0] conversions_per_result,
	input wire logic [4:0] results_per_request,
	input wire logic [RESULT_BITS-1:0] temp_celsius_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] eu, eb;
	logic [5:0] ecpr;
	logic [4:0] erpr;
	logic [RESULT_BITS-1:0] etemp;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			eu[i] = unipolar_pair_enable[7-i] && (2 * i + 1 < NUM_CHANNELS);
			eb[i] = bipolar_pair_enable[7-i] && !eu[i] && (2 * i + 1 < NUM_CHANNELS);
		end
		// Clock mode 11 forces single conversions
		if (!averaging_config[AVG_EN_BIT] || setup_config[5:4] == CLK_MODE_SER_EXT) begin
			ecpr = AVG_N1;
		end else begin
			ecpr = AVG_N4 << averaging_config[3:2];
		end
		erpr = REPEAT_STEP * ({3'h0, averaging_config[1:0]} + 5'h01);
		if (conv_scan_mode != SCAN_MODE_REPEAT) begin
			erpr = REPEAT_ONE;
		end
		etemp = temp_hot_code - temp_cold_code - TEMP_KELVIN_OFFSET;
	end
	property p_pair_uni;
		$stable(unipolar_pair_enable) |-> pair_unipolar == eu;
	endproperty
	a_pair_uni: assert property (p_pair_uni) else $error("unipolar pair map wrong");
	property p_pair_bi;
		$stable(unipolar_pair_enable) && $stable(bipolar_pair_enable) |-> pair_bipolar == eb;
	endproperty
	a_pair_bi: assert property (p_pair_bi) else $error("bipolar pair map wrong");
	property p_ref_on;
		(setup_config[3:2] == REF_MODE_INT_ON) [*2] |-> ref_power_en;
	endproperty
	a_ref_on: assert property (p_ref_on) else $error("reference not kept on");
	property p_ref_auto;
		(setup_config[3:2] == REF_MODE_INT_AUTO) [*2] |-> ref_power_en == $past(scan_active);
	endproperty
	a_ref_auto: assert property (p_ref_auto) else $error("reference not tied to scan");
	property p_cpr;
		conversions_per_result == $past(ecpr);
	endproperty
	a_cpr: assert property (p_cpr) else $error("averaging count wrong");
	property p_rpr;
		results_per_request == $past(erpr);
	endproperty
	a_rpr: assert property (p_rpr) else $error("repeat count wrong");
	property p_temp;
		temp_codes_valid |=> temp_celsius_code == $past(etemp);
	endproperty
	a_temp: assert property (p_temp) else $error("temperature code wrong");
	property p_stb;
		setup_config[SETUP_CLK_HI] && $stable(setup_config) |-> start_conversion == conv_byte_stb;
	endproperty
	a_stb: assert property (p_stb) else $error("byte start wrong");
	property p_pin;
		$rose(conversion_start_pin) && !setup_config[SETUP_CLK_HI] |-> ##[2:4] start_conversion;
	endproperty
	a_pin: assert property (p_pin) else $error("pin start missing");
	property p_wake;
		(setup_config[3:2] == REF_MODE_INT_AUTO) [*2] |-> ref_wake_required == !$past(ref_power_en);
	endproperty
	a_wake: assert property (p_wake) else $error("reference wake flag wrong");
	property p_no_wake;
		setup_config[3:2] != REF_MODE_INT_AUTO |-> !ref_wake_required;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("wake delay outside mode 00");
	property p_conv_clk;
		conv_clk_en |-> $past(setup_config[5:4]) == CLK_MODE_SER_EXT;
	endproperty
	a_conv_clk: assert property (p_conv_clk) else $error("serial conversion clock wrong");
	property p_oe;
		!cs_n [*4] |-> dout_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("output not enabled in frame");
	c_clk: cover property (conv_clk_en);
	c_stb: cover property (conv_byte_stb && start_conversion);
	c_temp: cover property (temp_codes_valid);
	c_bi: cover property (pair_bipolar != 8'h00);
endmodule

`default_nettype wire

// ===== verif/acfg_host.sv
// Host serial master model: frames of up to 16 bits, MSB first.
// Assumes the caller starts a frame just after a rising clk edge.
`timescale 1ns/100ps
`default_nettype none

module acfg_host (
	input wire logic clk,
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Eight clk per serial bit: 3.125 MHz, under the ceiling
	task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
		r = 16'h0000;
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			din <= w[nb-1-i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			r = {r[14:0], dout};
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		// Released line must not keep looking valid
		din <= ~din;
		repeat (4) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// ===== verif/tb_adc_setup_averaging_config.sv
// Bench for the converter configuration decoder, twelve-input variant.
// Host model drives the serial pins; the bench plays the converter side.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_adc_setup_averaging_config;
	import acfg_pkg::*;
	localparam logic [7:0] PMASK = 8'h3f;
	localparam logic [11:0] TOFF = 12'h889;
	logic clk, rst, cs_n, sclk, din, dout, dout_oe, conversion_start_pin, scan_active;
	logic conv_result_valid, conv_result_bipolar, temp_codes_valid, conv_byte_stb;
	logic start_conversion, acquire_hold, conv_clk_en, use_internal_clock, start_pin_used;
	logic ref_use_internal, ref_power_en, ref_wake_required, ref_ext_diff;
	logic [1:0] conv_scan_mode;
	logic [11:0] conv_result_code, temp_hot_code, temp_cold_code, temp_celsius_code, h, c;
	logic [7:0] setup_config, unipolar_pair_enable, bipolar_pair_enable, averaging_config;
	logic [7:0] conv_byte, pair_unipolar, pair_bipolar, su, up, bp, av, b, d;
	logic [5:0] conversions_per_result;
	logic [4:0] results_per_request;
	logic [15:0] r;
	logic [2:0] cyc;
	int bad_count = 0;
	int comparisons = 0;
	int seed = 29;
	int starts = 0;
	int s0;

	acfg_config #(.NUM_CHANNELS(12), .TEMP_KELVIN_OFFSET(TOFF)) dut_u (.*);
	acfg_host host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

	initial clk = 1'b0;
	always #20 clk = ~clk;

	always @(posedge clk) begin
		cyc <= rst ? 3'h0 : cyc + 3'h1;
		scan_active <= cyc[2];
		if (start_conversion === 1'b1) begin
			starts <= starts + 1;
		end
	end

	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++) rev[i] = v[7-i];
	endfunction

	function automatic logic [5:0] f_cpr(input logic [7:0] s, input logic [7:0] a);
		if (!a[4] || s[5:4] == 2'h3) return 6'h01;
		return 6'h04 << a[3:2];
	endfunction

	task automatic finish_test();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_regs();
		repeat (6) @(posedge clk);
		`CHK(setup_config, su)
		`CHK(unipolar_pair_enable, up)
		`CHK(bipolar_pair_enable, bp)
		`CHK(averaging_config, av)
		`CHK(pair_unipolar, rev(up) & PMASK)
		`CHK(pair_bipolar, rev(bp) & ~rev(up) & PMASK)
		`CHK(conversions_per_result, f_cpr(su, av))
		`CHK(use_internal_clock, su[5:4] != 2'h3)
		`CHK(start_pin_used, !su[5])
		`CHK(acquire_hold, su[5:4] == 2'h1)
		`CHK(ref_use_internal, !su[2])
		`CHK(ref_ext_diff, su[3:2] == 2'h3)
		`CHK(dout_oe, 1'b0)
	endtask

	task automatic read_word(input logic [15:0] e);
		host_u.xfer(16'h0000, 16, r);
		`CHK(r, e)
	endtask

	initial begin
		rst = 1'b1;
		conversion_start_pin = 1'b0;
		conv_scan_mode = 2'h0;
		conv_result_valid = 1'b0;
		conv_result_code = 12'h000;
		conv_result_bipolar = 1'b0;
		temp_codes_valid = 1'b0;
		temp_hot_code = 12'h000;
		temp_cold_code = 12'h000;
		su = SETUP_RESET;
		up = 8'h00;
		bp = 8'h00;
		av = 8'h00;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk_regs();
		`CHK(results_per_request, REPEAT_ONE)
		// Data byte shaped like a setup byte
		host_u.xfer(16'h4a4b, 16, r);
		su = 8'h4a;
		up = 8'h4b;
		chk_regs();
		s0 = starts;
		conversion_start_pin <= 1'b1;
		repeat (8) @(posedge clk);
		conversion_start_pin <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(starts - s0, 1)
		host_u.xfer(16'h0040, 8, r);
		su = 8'h40;
		conv_scan_mode <= SCAN_MODE_REPEAT;
		for (int k = 0; k < 4; k++) begin
			av = {4'h3, 2'(k), 2'(k)};
			host_u.xfer({8'h00, av}, 8, r);
			chk_regs();
			`CHK(results_per_request, 5'(4 * k + 4))
		end
		conv_scan_mode <= 2'h3;
		for (int n = 0; n < 24; n++) begin
			b = 8'($random(seed));
			d = 8'($random(seed));
			if (n % 3 == 2) begin
				av = {3'b001, b[4:0]};
				host_u.xfer({8'h00, av}, 8, r);
			end else begin
				su = {2'b01, b[5:0]};
				if (su[1]) begin
					host_u.xfer({su, d}, 16, r);
				end else begin
					host_u.xfer({8'h00, su}, 8, r);
				end
				up = (su[1:0] == 2'b10) ? d : up;
				bp = (su[1:0] == 2'b11) ? d : bp;
			end
			chk_regs();
		end
		`CHK(results_per_request, REPEAT_ONE)
		// Mode 11 first, so the next frame clocks the converter
		host_u.xfer(16'h0070, 8, r);
		host_u.xfer(16'h0060, 8, r);
		s0 = starts;
		conversion_start_pin <= 1'b1;
		repeat (8) @(posedge clk);
		conversion_start_pin <= 1'b0;
		host_u.xfer(16'h0086, 8, r);
		`CHK(starts - s0, 1)
		`CHK(conv_byte, 8'h86)
		h = 12'($random(seed));
		c = 12'($random(seed));
		temp_hot_code <= h;
		temp_cold_code <= c;
		temp_codes_valid <= 1'b1;
		@(posedge clk) temp_codes_valid <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(temp_celsius_code, h - c - TOFF)
		read_word({4'h0, h - c - TOFF});
		for (int k = 0; k < 2; k++) begin
			h = 12'($random(seed));
			conv_result_code <= h;
			conv_result_bipolar <= k[0];
			conv_result_valid <= 1'b1;
			@(posedge clk) conv_result_valid <= 1'b0;
			read_word({4'h0, k[0] ? h ^ BIPOLAR_FLIP : h});
		end
		// Second reset after every register has been written
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		su = SETUP_RESET;
		up = 8'h00;
		bp = 8'h00;
		av = 8'h00;
		chk_regs();
		finish_test();
	end

	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		finish_test();
	end
endmodule

bind acfg_config acfg_config_asserts #(.NUM_CHANNELS(NUM_CHANNELS),
	.TEMP_KELVIN_OFFSET(TEMP_KELVIN_OFFSET)) chk_u (
	.clk(clk),
	.rst(rst),
	.cs_n(cs_n),
	.conversion_start_pin(conversion_start_pin),
	.scan_active(scan_active),
	.conv_scan_mode(conv_scan_mode),
	.temp_codes_valid(temp_codes_valid),
	.temp_hot_code(temp_hot_code),
	.temp_cold_code(temp_cold_code),
	.setup_config(setup_config),
	.unipolar_pair_enable(unipolar_pair_enable),
	.bipolar_pair_enable(bipolar_pair_enable),
	.averaging_config(averaging_config),
	.conv_byte_stb(conv_byte_stb),
	.start_conversion(start_conversion),
	.dout_oe(dout_oe),
	.conv_clk_en(conv_clk_en),
	.ref_power_en(ref_power_en),
	.ref_wake_required(ref_wake_required),
	.pair_unipolar(pair_unipolar),
	.pair_bipolar(pair_bipolar),
	.conversions_per_result(conversions_per_result),
	.results_per_request(results_per_request),
	.temp_celsius_code(temp_celsius_code)
);

`default_nettype wire
